/* File: common/gpc_defs.vh */
// register offsets, field positions, reset values of the change-interrupt port
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH
`define GPC_ADDR_W        4
`define GPC_OFS_PINS      4'h0
`define GPC_OFS_LATCH     4'h1
`define GPC_OFS_DIR       4'h2
`define GPC_OFS_PULLUP    4'h3
`define GPC_OFS_IRQ_CTL2  4'h4
`define GPC_OFS_IRQ_CTL1  4'h5
`define GPC_OFS_CHG_EN    4'h6
`define GPC_OFS_ANALOG    4'h7
`define GPC_OFS_MOVE_SRC  4'h8
`define GPC_BIT_PU_DIS    7
`define GPC_BIT_CHG_FLAG  0
`define GPC_BIT_CHG_GEN   3
`define GPC_RST_DIR       8'hFF
`define GPC_RST_LATCH     8'h00
`define GPC_RST_PULLUP    8'h00
`define GPC_RST_CHG_EN    4'h0
`define GPC_RST_CHG_GEN   1'h0
`define GPC_RST_FLAG      1'h0
`define GPC_RST_MOVE      1'h0
`define GPC_RST_SNAP      4'h0
`define GPC_RST_PU_DIS    1'h1
`define GPC_ANA_ON        5'h1F
`define GPC_ANA_OFF       5'h00
`endif

/* File: design/gpc_port.v */
// eight-pin bidirectional port with pull-ups and change interrupt
//
// Summary of operation
// - eight bidirectional pins, each with direction, latch and input path
// - direction bit one turns the pin driver off
// - direction bit zero drives the latch bit onto the pin
// - latch register has its own address and reads back latched values
// - pull-up on only when per-pin enable set and global disable clear
// - global disable turns all pull-ups off
// - pull-up forced off while the pin is an output
// - pull-ups disabled after power-on reset
// - pins 4..0 analog reading zero, pins 7..5 digital after power-on
// - analog-default select one makes pins 4..0 digital at power-on
// - only pins 7..4 have change interrupt, each with own enable
// - global change enable gates every change request
// - output pins excluded from the change comparison
// - enabled pins compared against snapshot from last port access
// - mismatches ORed together set the change flag
// - pending change request wakes device from sleep and idle
// - port access ends mismatch, except memory-to-memory move
// - flag set again while a mismatch persists
// - snapshot survives reset-pin and brown-out resets
// - change coinciding with a port read still sets the flag
`timescale 1ns/1ns
`include "gpc_defs.vh"

module gpc_port (
  input  wire                   clock,
  input  wire                   reset_n,
  input  wire                   por_n,
  input  wire                   por_analog_default_select,
  input  wire [`GPC_ADDR_W-1:0] addr,
  input  wire [7:0]             wdata,
  input  wire                   wr,
  input  wire                   rd,
  output reg  [7:0]             rdata,
  input  wire [7:0]             pin_in,
  output reg  [7:0]             pin_out,
  output reg  [7:0]             pin_oe,
  output reg  [7:0]             pullup_on,
  output reg                    change_irq_req,
  output reg                    wake_req
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] pin_direction_bits_r;
reg [7:0] output_latch_bits_r;
reg [7:0] pullup_enable_bits_r;
reg       pullup_global_disable_r;
reg [3:0] change_irq_enable_bits_r;
reg       change_irq_global_enable_r;
reg       change_irq_flag_r;
reg [4:0] analog_select_high_r;
reg       move_src_r;
reg [7:0] sync1_r;
reg [7:0] sync2_r;
reg [7:0] sync3_r;
reg [7:0] pins_r;
reg [3:0] snapshot_r;
reg       strap_pending_r;
reg [7:0] output_latch_bits_nxt;
reg [7:0] pin_direction_bits_nxt;
reg [7:0] pullup_enable_bits_nxt;
reg       pullup_global_disable_nxt;
reg [3:0] change_irq_enable_bits_nxt;
reg       change_irq_global_enable_nxt;
reg       change_irq_flag_nxt;
reg       move_src_nxt;
reg [7:0] rdata_nxt;
reg [3:0] snapshot_nxt;
reg [4:0] analog_select_high_nxt;

////////////////////////////////////////////////////////////////////////////////
// helpers
function hit;
  input [`GPC_ADDR_W-1:0] a;
  input [`GPC_ADDR_W-1:0] ofs;
  input                   strobe;
  begin
    hit = strobe && (a == ofs);
  end
endfunction

// agreeing second and third stages replace the filtered value
function [7:0] settle;
  input [7:0] s2;
  input [7:0] s3;
  input [7:0] held;
  begin
    settle = (s2 & s3) | (held & (s2 ^ s3));
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// input synchroniser and change detect
// a bit updates only when second and third stage agree
wire [7:0] pins_nxt = settle(sync2_r, sync3_r, pins_r);

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    sync1_r <= 8'h00;
    sync2_r <= 8'h00;
    sync3_r <= 8'h00;
  end else begin
    sync1_r <= pin_in;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    pins_r <= 8'h00;
  end else begin
    pins_r <= pins_nxt;
  end
end

// digital read path: analog-selected pins read zero
wire [7:0] digital_pins = pins_r & ~{3'h0, analog_select_high_r};

wire port_access = (hit(addr, `GPC_OFS_PINS, rd) || hit(addr, `GPC_OFS_PINS, wr))
                   && !move_src_r;
wire [3:0] mismatch = (digital_pins[7:4] ^ snapshot_r)
                      & change_irq_enable_bits_r
                      & pin_direction_bits_r[7:4];
wire any_mismatch = |mismatch;

always @* begin
  snapshot_nxt = snapshot_r;
  if (port_access) begin
    snapshot_nxt = digital_pins[7:4];
  end
end

// snapshot only cleared on power-on, kept across reset-pin and brown-out
always @(posedge clock or negedge por_n) begin
  if (!por_n) begin
    snapshot_r <= `GPC_RST_SNAP;
  end else begin
    snapshot_r <= snapshot_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// control registers
wire wr_pins   = hit(addr, `GPC_OFS_PINS, wr);
wire wr_latch  = hit(addr, `GPC_OFS_LATCH, wr);
wire wr_dir    = hit(addr, `GPC_OFS_DIR, wr);
wire wr_pullup = hit(addr, `GPC_OFS_PULLUP, wr);
wire wr_ctl2   = hit(addr, `GPC_OFS_IRQ_CTL2, wr);
wire wr_ctl1   = hit(addr, `GPC_OFS_IRQ_CTL1, wr);
wire wr_chg_en = hit(addr, `GPC_OFS_CHG_EN, wr);
wire wr_analog = hit(addr, `GPC_OFS_ANALOG, wr);
wire wr_move   = hit(addr, `GPC_OFS_MOVE_SRC, wr);

// port address and latch address both land in the latch
always @* begin
  output_latch_bits_nxt = output_latch_bits_r;
  if (wr_pins || wr_latch) begin
    output_latch_bits_nxt = wdata;
  end
end

always @* begin
  pin_direction_bits_nxt = pin_direction_bits_r;
  if (wr_dir) begin
    pin_direction_bits_nxt = wdata;
  end
end

always @* begin
  pullup_enable_bits_nxt = pullup_enable_bits_r;
  if (wr_pullup) begin
    pullup_enable_bits_nxt = wdata;
  end
end

always @* begin
  pullup_global_disable_nxt = pullup_global_disable_r;
  if (wr_ctl2) begin
    pullup_global_disable_nxt = wdata[`GPC_BIT_PU_DIS];
  end
end

always @* begin
  change_irq_enable_bits_nxt = change_irq_enable_bits_r;
  if (wr_chg_en) begin
    change_irq_enable_bits_nxt = wdata[7:4];
  end
end

always @* begin
  change_irq_global_enable_nxt = change_irq_global_enable_r;
  if (wr_ctl1) begin
    change_irq_global_enable_nxt = wdata[`GPC_BIT_CHG_GEN];
  end
end

always @* begin
  move_src_nxt = move_src_r;
  if (wr_move) begin
    move_src_nxt = wdata[0];
  end
end

// set wins over the software clear
always @* begin
  change_irq_flag_nxt = change_irq_flag_r;
  if (any_mismatch) begin
    change_irq_flag_nxt = 1'h1;
  end else if (wr_ctl1) begin
    change_irq_flag_nxt = wdata[`GPC_BIT_CHG_FLAG];
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    output_latch_bits_r <= `GPC_RST_LATCH;
  end else begin
    output_latch_bits_r <= output_latch_bits_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    pin_direction_bits_r <= `GPC_RST_DIR;
  end else begin
    pin_direction_bits_r <= pin_direction_bits_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    pullup_enable_bits_r <= `GPC_RST_PULLUP;
  end else begin
    pullup_enable_bits_r <= pullup_enable_bits_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    pullup_global_disable_r <= `GPC_RST_PU_DIS;
  end else begin
    pullup_global_disable_r <= pullup_global_disable_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    change_irq_enable_bits_r <= `GPC_RST_CHG_EN;
  end else begin
    change_irq_enable_bits_r <= change_irq_enable_bits_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    change_irq_global_enable_r <= `GPC_RST_CHG_GEN;
  end else begin
    change_irq_global_enable_r <= change_irq_global_enable_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    change_irq_flag_r <= `GPC_RST_FLAG;
  end else begin
    change_irq_flag_r <= change_irq_flag_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    move_src_r <= `GPC_RST_MOVE;
  end else begin
    move_src_r <= move_src_nxt;
  end
end

// analog select loaded from strap only on power-on, after release
always @* begin
  analog_select_high_nxt = analog_select_high_r;
  if (strap_pending_r) begin
    analog_select_high_nxt = por_analog_default_select ? `GPC_ANA_OFF : `GPC_ANA_ON;
  end else if (wr_analog) begin
    analog_select_high_nxt = wdata[4:0];
  end
end

always @(posedge clock or negedge por_n) begin
  if (!por_n) begin
    strap_pending_r      <= 1'h1;
    analog_select_high_r <= `GPC_ANA_ON;
  end else begin
    strap_pending_r      <= 1'h0;
    analog_select_high_r <= analog_select_high_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// read data and pin outputs
always @* begin
  rdata_nxt = 8'h00;
  if (rd) begin
    case (addr)
      `GPC_OFS_PINS:     rdata_nxt = digital_pins;
      `GPC_OFS_LATCH:    rdata_nxt = output_latch_bits_r;
      `GPC_OFS_DIR:      rdata_nxt = pin_direction_bits_r;
      `GPC_OFS_PULLUP:   rdata_nxt = pullup_enable_bits_r;
      `GPC_OFS_IRQ_CTL2: rdata_nxt = {pullup_global_disable_r, 7'h00};
      `GPC_OFS_IRQ_CTL1: rdata_nxt = {4'h0, change_irq_global_enable_r, 2'h0,
                                      change_irq_flag_r};
      `GPC_OFS_CHG_EN:   rdata_nxt = {change_irq_enable_bits_r, 4'h0};
      `GPC_OFS_ANALOG:   rdata_nxt = {3'h0, analog_select_high_r};
      `GPC_OFS_MOVE_SRC: rdata_nxt = {7'h00, move_src_r};
      default:           rdata_nxt = 8'h00;
    endcase
  end
end

wire [7:0] pullup_on_nxt = pullup_enable_bits_r & pin_direction_bits_r
                           & {8{~pullup_global_disable_r}};
wire       change_pending = change_irq_flag_r & change_irq_global_enable_r;

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    rdata <= 8'h00;
  end else begin
    rdata <= rdata_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    pin_out <= 8'h00;
  end else begin
    pin_out <= output_latch_bits_r;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    pin_oe <= 8'h00;
  end else begin
    pin_oe <= ~pin_direction_bits_r;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    pullup_on <= 8'h00;
  end else begin
    pullup_on <= pullup_on_nxt;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    change_irq_req <= 1'h0;
  end else begin
    change_irq_req <= change_pending;
  end
end

always @(posedge clock or negedge reset_n) begin
  if (!reset_n) begin
    wake_req <= 1'h0;
  end else begin
    wake_req <= change_pending;
  end
end

endmodule

/* File: tb/gpc_port_props.sv */
// checker for the change-interrupt port
`timescale 1ns/1ns
module gpc_port_props (
  input wire       clock,
  input wire       reset_n,
  input wire       por_n,
  input wire       wr,
  input wire       rd,
  input wire       change_irq_req,
  input wire       wake_req,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pullup_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n || !por_n);
  chk_oe_dir: assert property (wr && addr == 4'h2 |=> ##1 pin_oe == ~$past(wdata, 2))
    else $error("driver enable wrong");
  chk_out_latch: assert property (wr && addr == 4'h1 |=> ##1 pin_out == $past(wdata, 2))
    else $error("pin output wrong");
  chk_latch_back: assert property (wr && addr == 4'h1 ##1 rd && addr == 4'h1 |=>
    rdata == $past(wdata, 2)) else $error("latch readback wrong");
  chk_pu_output: assert property ((pullup_on & pin_oe) == 8'h00)
    else $error("pull-up on an output");
  chk_pu_global: assert property (wr && addr == 4'h4 && wdata[7] |=> ##1 pullup_on == 8'h00)
    else $error("pull-up survives global off");
  chk_por_pu: assert property ($rose(por_n) |-> pullup_on == 8'h00)
    else $error("pull-up on after power-on");
  chk_gen_off: assert property (wr && addr == 4'h5 && !wdata[3] |=> ##1 !change_irq_req)
    else $error("request with global enable off");
  chk_wake_req: assert property (wake_req == change_irq_req)
    else $error("wake differs from request");
  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside slot");
  cover property ($rose(change_irq_req));
  cover property (rd && addr == 4'h0);
  cover property (wr && addr == 4'h4 && wdata[7]);
endmodule
bind gpc_port gpc_port_props PROPS (.*);

/* File: tb/gpc_pins_model.sv */
// far-side pin model: board drivers, weak pull-ups, floating level
`timescale 1ns/1ns
module gpc_pins_model (
  input  wire       clock,
  input  wire [7:0] pin_out, pin_oe, pullup_on, ext_en, ext_val,
  output wire [7:0] pin_in
);
  reg flip_r = 1'b0;
  always @(posedge clock) flip_r <= ~flip_r;
  // undriven pin without pull-up wanders each cycle
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pullup_on | {8{flip_r}}));
endmodule

/* File: tb/test_gpio_port_pullup_change_irq.sv */
// self-checking bench for the change-interrupt port
`timescale 1ns/1ns
module test_gpio_port_pullup_change_irq;
  reg        clock = 0, reset_n = 0, por_n = 0, por_analog_default_select = 0, wr = 0, rd = 0;
  reg  [3:0] addr = 4'h0;
  reg  [7:0] wdata = 8'h00, ext_en = 8'hFF, ext_val = 8'hFF;
  wire [7:0] rdata, pin_in, pin_out, pin_oe, pullup_on;
  wire       change_irq_req, wake_req;
  logic [7:0] got;
  int mismatches = 0, checks = 0;
  always #50 clock = ~clock;
  gpc_port DUT (.clock(clock), .reset_n(reset_n), .por_n(por_n), .addr(addr), .wdata(wdata),
    .por_analog_default_select(por_analog_default_select), .wr(wr), .rd(rd), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
    .change_irq_req(change_irq_req), .wake_req(wake_req));
  gpc_pins_model PINS (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task cmp(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a);
    @(posedge clock);
    rd <= 1'b1; addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task do_reset(input logic pwr, input logic strap);
    @(posedge clock);
    reset_n <= 1'b0; por_n <= ~pwr; por_analog_default_select <= strap;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1; por_n <= 1'b1;
    wait_n(2);
  endtask
  task t_por;
    cmp(pullup_on, 8'h00);
    rreg(2); cmp(got, 8'hFF);
    rreg(1); cmp(got, 8'h00);
    rreg(4); cmp(got & 8'h80, 8'h80);
    rreg(0); cmp(got, 8'hE0);
    rreg(9); cmp(got, 8'h00);
    $display("t_por done");
  endtask
  task t_drive;
    wreg(7, 8'h00); wreg(1, 8'hA5); wreg(2, 8'h0F); ext_val <= 8'h00;
    wait_n(5);
    cmp(pin_oe, 8'hF0);
    cmp(pin_out, 8'hA5);
    rreg(1); cmp(got, 8'hA5);
    rreg(0); cmp(got, 8'hA0);
    wreg(3, 8'hFF); wreg(4, 8'h00); wait_n(2);
    cmp(pullup_on, 8'h0F);
    wreg(4, 8'h80); wait_n(2);
    cmp(pullup_on, 8'h00);
    @(posedge clock); wr <= 1'b1; addr <= 4'h1; wdata <= 8'h5A;
    @(posedge clock); wr <= 1'b0; rd <= 1'b1;
    @(posedge clock); rd <= 1'b0;
    #1 cmp(rdata, 8'h5A);
    wreg(1, 8'hA5);
    $display("t_drive done");
  endtask
  task t_change;
    wreg(2, 8'hFF); wait_n(5); rreg(0); wreg(6, 8'hF0); wreg(5, 8'h08); wait_n(3);
    cmp(change_irq_req, 1'b0);
    ext_val <= 8'h20; wait_n(8);
    cmp(change_irq_req, 1'b1);
    cmp(wake_req, 1'b1);
    wreg(5, 8'h08); wait_n(3); cmp(change_irq_req, 1'b1);
    wreg(8, 8'h01); rreg(0); wreg(5, 8'h08); wait_n(3); cmp(change_irq_req, 1'b1);
    wreg(8, 8'h00); rreg(0); wreg(5, 8'h08); wait_n(3); cmp(change_irq_req, 1'b0);
    ext_val <= 8'h40; wait_n(8); do_reset(1'b0, 1'b0);
    wreg(6, 8'hF0); wreg(5, 8'h08); wait_n(4); cmp(change_irq_req, 1'b1);
    wreg(5, 8'h00); wait_n(3); cmp(change_irq_req, 1'b0);
    rreg(0); wreg(5, 8'h08); wreg(2, 8'hBF); wait_n(8); cmp(change_irq_req, 1'b0);
    wreg(6, 8'h80); wreg(2, 8'hFF); ext_val <= 8'h00; wait_n(8);
    cmp(change_irq_req, 1'b0);
    $display("t_change done");
  endtask
  task t_strap;
    ext_val <= 8'hFF; do_reset(1'b1, 1'b1); wait_n(4);
    rreg(0); cmp(got, 8'hFF);
    $display("t_strap done");
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    close_out;
  end
  initial begin
    do_reset(1'b1, 1'b0);
    t_por;
    t_drive;
    t_change;
    t_strap;
    close_out;
  end
endmodule
